// ---- ibtl_pkg.sv ----
// package: constants and types for the instrument bus talker/listener
package ibtl_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned SETTLE_NS = 20;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [6:0] LAD_LO = 7'h20;
  localparam logic [6:0] LAD_HI = 7'h3E;
  localparam logic [6:0] UNL_CODE = 7'h3F;
  localparam logic [6:0] TAD_LO = 7'h40;
  localparam logic [6:0] TAD_HI = 7'h5E;
  localparam logic [6:0] UNT_CODE = 7'h5F;
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam int unsigned SRQ_BIT = 6;
  localparam logic [7:0] TERM_DEFAULT = 8'h0A;
  typedef enum logic [1:0] {
    IBTL_AH_IDLE = 2'b00,
    IBTL_AH_READY = 2'b01,
    IBTL_AH_TAKE = 2'b10,
    IBTL_AH_DONE = 2'b11
  } ibtl_ah_t;
  typedef enum logic [1:0] {
    IBTL_SH_IDLE = 2'b00,
    IBTL_SH_SETTLE = 2'b01,
    IBTL_SH_VALID = 2'b10,
    IBTL_SH_WAIT = 2'b11
  } ibtl_sh_t;
endpackage

// ---- ibtl_sync_if.sv ----
// interface: synchronised bus line levels between synchroniser and core
`timescale 1ns/100ps
interface ibtl_sync_if;
  logic [7:0] dio;
  logic atn;
  logic ren;
  logic dav;
  logic nrfd;
  logic ndac;
  logic eoi;
  logic ifc;
  modport src (output dio, atn, ren, dav, nrfd, ndac, eoi, ifc);
  modport dst (input dio, atn, ren, dav, nrfd, ndac, eoi, ifc);
endinterface

// ---- ibtl_sync.sv ----
// module: two-flop synchronisers for every bus input, converted to true-high
`timescale 1ns/100ps
module ibtl_sync (
  input wire logic mclk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [7:0] dio_n_i, // data lines, low true
  input wire logic [6:0] ctl_n_i, // atn ren dav nrfd ndac eoi ifc, low true
  ibtl_sync_if.src so // synchronised true-high levels
);
  import ibtl_pkg::*;
  logic [14:0] s1_q;
  logic [14:0] s2_q;

  // first stage is read only by second stage
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 15'h0000;
      s2_q <= 15'h0000;
    end else begin
      s1_q <= ~{dio_n_i, ctl_n_i};
      s2_q <= s1_q;
    end
  end

  assign so.dio = s2_q[14:7];
  assign so.atn = s2_q[6];
  assign so.ren = s2_q[5];
  assign so.dav = s2_q[4];
  assign so.nrfd = s2_q[3];
  assign so.ndac = s2_q[2];
  assign so.eoi = s2_q[1];
  assign so.ifc = s2_q[0];
endmodule

// ---- ibtl_core.sv ----
// module: talker/listener interface core for a negative-true instrument bus
`timescale 1ns/100ps
module ibtl_core (
  input wire logic mclk, // system clock, 100 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic [7:0] dio_n_i, // data lines in, low true
  output logic [7:0] dio_n_o, // data lines out, low true
  output logic [7:0] dio_oe, // data line drive enables
  input wire logic atn_n_i, // attention, low true
  input wire logic ren_n_i, // remote enable, low true
  input wire logic ifc_n_i, // interface clear, low true
  input wire logic eoi_n_i, // end or identify in
  output logic eoi_n_o, // end or identify out
  output logic eoi_oe, // eoi drive enable
  input wire logic dav_n_i, // data valid in
  output logic dav_n_o, // data valid out
  output logic dav_oe, // dav drive enable
  input wire logic nrfd_n_i, // not ready for data in
  output logic nrfd_n_o, // nrfd out
  output logic nrfd_oe, // nrfd drive enable
  input wire logic ndac_n_i, // not data accepted in
  output logic ndac_n_o, // ndac out
  output logic ndac_oe, // ndac drive enable
  output logic srq_n_o, // service request out
  output logic srq_oe, // srq drive enable
  input wire logic [4:0] my_addr, // primary address, static strap
  input wire logic [7:0] term_char, // terminator character
  input wire logic srq_enable, // software selects service request
  input wire logic srq_set, // pulse: raise service request
  output logic [7:0] rx_data, // received byte
  output logic rx_valid, // held until rx_ready: rx_data holds a byte
  input wire logic rx_ready, // parser can take a byte
  input wire logic [7:0] tx_data, // byte to send
  input wire logic tx_last, // tx_data is the terminator
  input wire logic tx_valid, // byte offered
  output logic tx_ready, // byte taken
  input wire logic local_key, // pulse: front-panel local key
  output logic remote, // remote state
  output logic lockout, // local lockout state
  output logic listener, // addressed to listen
  output logic talker, // addressed to talk
  output logic dev_clear, // pulse: device clear
  output logic dev_trigger, // pulse: device trigger
  output logic srq_pending // service requested
);
  import ibtl_pkg::*;

  // ----------------------------------------
  // synchronised inputs
  // ----------------------------------------
  ibtl_sync_if sb ();
  ibtl_sync u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .dio_n_i(dio_n_i),
    .ctl_n_i({atn_n_i, ren_n_i, dav_n_i, nrfd_n_i, ndac_n_i, eoi_n_i, ifc_n_i}),
    .so(sb)
  );

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  ibtl_ah_t ah_q, ah_d;
  ibtl_sh_t sh_q, sh_d;
  logic [7:0] rxb_q;
  logic rxe_q;
  logic rxatn_q;
  logic term_q;
  logic lad_q, tad_q, spe_q, rem_q, llo_q, srq_q;
  logic [7:0] settle_q;

  wire byte_in = (ah_q == IBTL_AH_TAKE);
  wire [6:0] code = rxb_q[6:0];
  wire is_cmd = byte_in && rxatn_q;
  wire is_data = byte_in && !rxatn_q;
  // secondaries (60..7F) fall through every compare: ignored
  wire my_lad = is_cmd && code >= LAD_LO && code <= LAD_HI && code[4:0] == my_addr;
  wire my_tad = is_cmd && code >= TAD_LO && code <= TAD_HI && code[4:0] == my_addr;
  wire unl = is_cmd && code == UNL_CODE;
  wire unt = is_cmd && code == UNT_CODE;
  wire other_tad = is_cmd && code[6:5] == 2'b10 && !my_tad;
  wire dcl_hit = is_cmd && (code == CMD_DCL || (code == CMD_SDC && lad_q));
  wire get_hit = is_cmd && code == CMD_GET && lad_q;
  wire gtl_hit = is_cmd && code == CMD_GTL && lad_q;
  wire llo_hit = is_cmd && code == CMD_LLO;
  wire spe_hit = is_cmd && code == CMD_SPE;
  wire spd_hit = is_cmd && code == CMD_SPD;
  wire rx_fire = rx_valid && rx_ready;
  wire talk_act = tad_q && !sb.atn;
  wire poll_read = talk_act && spe_q && sh_q == IBTL_SH_WAIT && sb.ndac == 1'b0;
  wire sh_src_ok = talk_act && (spe_q || tx_valid);
  wire [7:0] status = {1'b0, srq_q, 6'h00};

  // ----------------------------------------
  // acceptor handshake
  // ----------------------------------------
  // attention bytes must be accepted even when the parser stalls
  wire ah_act = sb.atn || (lad_q && !term_q && !rx_valid);
  always_comb begin
    ah_d = ah_q;
    unique case (ah_q)
      // a dav still seen here may be our own, late through the synchroniser
      IBTL_AH_IDLE: if (ah_act && !sb.dav) ah_d = IBTL_AH_READY;
      IBTL_AH_READY: if (!ah_act) ah_d = IBTL_AH_IDLE;
        else if (sb.dav) ah_d = IBTL_AH_TAKE;
      IBTL_AH_TAKE: ah_d = IBTL_AH_DONE;
      IBTL_AH_DONE: if (!sb.dav) ah_d = IBTL_AH_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ah_q <= IBTL_AH_IDLE;
      rxb_q <= 8'h00;
      rxe_q <= 1'b0;
      rxatn_q <= 1'b0;
    end else if (sb.ifc) begin
      ah_q <= IBTL_AH_IDLE;
    end else begin
      ah_q <= ah_d;
      if (ah_q == IBTL_AH_READY && sb.dav) begin
        rxb_q <= sb.dio;
        rxe_q <= sb.eoi;
        rxatn_q <= sb.atn;
      end
    end
  end

  // listener holds NRFD until ready, NDAC until byte taken
  assign nrfd_oe = (lad_q || sb.atn) && ah_q != IBTL_AH_READY;
  assign ndac_oe = (lad_q || sb.atn) && ah_q != IBTL_AH_DONE;
  assign nrfd_n_o = 1'b0;
  assign ndac_n_o = 1'b0;

  // ----------------------------------------
  // receive path with terminator insertion
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      term_q <= 1'b0;
    end else if (sb.ifc) begin
      rx_valid <= 1'b0;
      term_q <= 1'b0;
    end else if (is_data && lad_q) begin
      rx_valid <= 1'b1;
      rx_data <= rxb_q;
      term_q <= rxe_q;
    end else if (rx_fire && term_q) begin
      rx_data <= term_char;
      term_q <= 1'b0;
    end else if (rx_fire) begin
      rx_valid <= 1'b0;
    end
  end

  // ----------------------------------------
  // addressing, remote/local, poll, service request
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lad_q <= 1'b0;
      tad_q <= 1'b0;
      spe_q <= 1'b0;
      rem_q <= 1'b0;
      llo_q <= 1'b0;
      srq_q <= 1'b0;
      dev_clear <= 1'b0;
      dev_trigger <= 1'b0;
    end else begin
      dev_clear <= dcl_hit;
      dev_trigger <= get_hit;
      if (sb.ifc) begin
        lad_q <= 1'b0;
        tad_q <= 1'b0;
        spe_q <= 1'b0;
      end else begin
        if (my_lad) lad_q <= 1'b1;
        else if (unl) lad_q <= 1'b0;
        if (my_tad) tad_q <= 1'b1;
        else if (unt || other_tad) tad_q <= 1'b0;
        if (spe_hit) spe_q <= 1'b1;
        else if (spd_hit) spe_q <= 1'b0;
      end
      if (!sb.ren) begin
        rem_q <= 1'b0;
        llo_q <= 1'b0;
      end else begin
        if (my_lad) rem_q <= 1'b1;
        else if (gtl_hit || (local_key && !llo_q)) rem_q <= 1'b0;
        if (llo_hit) llo_q <= 1'b1;
      end
      // set wins over the read clear
      if (srq_set && srq_enable) srq_q <= 1'b1;
      else if (poll_read) srq_q <= 1'b0;
    end
  end

  assign srq_oe = srq_q;
  assign srq_n_o = 1'b0;

  // ----------------------------------------
  // source handshake
  // ----------------------------------------
  always_comb begin
    sh_d = sh_q;
    unique case (sh_q)
      IBTL_SH_IDLE: if (sh_src_ok) sh_d = IBTL_SH_SETTLE;
      IBTL_SH_SETTLE: if (!talk_act) sh_d = IBTL_SH_IDLE;
        else if (settle_q == 8'(SETTLE_CYC) && !sb.nrfd) sh_d = IBTL_SH_VALID;
      IBTL_SH_VALID: if (!talk_act) sh_d = IBTL_SH_IDLE;
        else sh_d = IBTL_SH_WAIT;
      IBTL_SH_WAIT: if (!talk_act || !sb.ndac) sh_d = IBTL_SH_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= IBTL_SH_IDLE;
      settle_q <= 8'h00;
      dio_n_o <= 8'hFF;
      eoi_n_o <= 1'b1;
    end else if (sb.ifc) begin
      sh_q <= IBTL_SH_IDLE;
      settle_q <= 8'h00;
    end else begin
      sh_q <= sh_d;
      if (sh_q == IBTL_SH_IDLE && sh_src_ok) begin
        dio_n_o <= ~(spe_q ? status : tx_data);
        eoi_n_o <= ~(!spe_q && tx_last);
        settle_q <= 8'h00;
      end else if (sh_q == IBTL_SH_SETTLE && settle_q != 8'(SETTLE_CYC)) begin
        settle_q <= settle_q + 8'h01;
      end
    end
  end

  // data lines driven only as active talker, never for a parallel poll
  wire drive = talk_act && sh_q != IBTL_SH_IDLE;
  assign dio_oe = {8{drive}};
  assign eoi_oe = drive && !eoi_n_o;
  assign dav_oe = sh_q == IBTL_SH_VALID || sh_q == IBTL_SH_WAIT;
  assign dav_n_o = 1'b0;
  assign tx_ready = talk_act && !spe_q && sh_q == IBTL_SH_WAIT && !sb.ndac;

  assign remote = rem_q;
  assign lockout = llo_q;
  assign listener = lad_q;
  assign talker = tad_q;
  assign srq_pending = srq_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_take;
    ah_q == IBTL_AH_TAKE;
  endsequence
  a_dav_after_ready: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(dav_oe) |-> !sb.nrfd)
    else $error("dav asserted while nrfd held");
  a_no_drive_atn: assert property (@(posedge mclk) disable iff (!rst_n)
    sb.atn |-> !dio_oe[0] && !eoi_oe)
    else $error("data lines driven under attention");
  a_ndac_release: assert property (@(posedge mclk) disable iff (!rst_n)
    s_take ##1 1'b1 |-> !ndac_oe)
    else $error("ndac not released after take");
  a_ifc_clears: assert property (@(posedge mclk) disable iff (!rst_n)
    sb.ifc |=> !lad_q && !tad_q && !spe_q)
    else $error("interface clear ignored");
  a_remote_entry: assert property (@(posedge mclk) disable iff (!rst_n)
    my_lad && sb.ren |=> remote)
    else $error("no remote on own listen address");
  a_remote_exit: assert property (@(posedge mclk) disable iff (!rst_n)
    !sb.ren |=> !remote)
    else $error("remote kept without ren");
  a_poll_clears: assert property (@(posedge mclk) disable iff (!rst_n)
    poll_read && !(srq_set && srq_enable) |=> !srq_oe)
    else $error("srq not released by poll");
  a_term_insert: assert property (@(posedge mclk) disable iff (!rst_n)
    rx_fire && term_q |=> rx_valid && rx_data == term_char)
    else $error("terminator not inserted");
  a_clear_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
    is_cmd && code == CMD_DCL |=> dev_clear)
    else $error("device clear missed");
endmodule

// ---- ibtl_ctl_model.sv ----
// behavioural bus controller: command/data source and data acceptor
`timescale 1ns/100ps
module ibtl_ctl_model (
  input wire logic mclk, // pacing clock
  input wire logic [7:0] dio_n, // resolved data lines
  input wire logic nrfd_n, // resolved not ready for data
  input wire logic ndac_n, // resolved not data accepted
  input wire logic dav_n, // resolved data valid
  input wire logic eoi_n, // resolved end or identify
  output logic [7:0] dio_c_n, // data drive, high = released
  output logic atn_c_n, // attention drive
  output logic eoi_c_n, // eoi drive
  output logic dav_c_n, // dav drive
  output logic nrfd_c_n, // nrfd drive
  output logic ndac_c_n // ndac drive
);
  initial begin
    dio_c_n = 8'hFF;
    atn_c_n = 1'b1;
    eoi_c_n = 1'b1;
    dav_c_n = 1'b1;
    nrfd_c_n = 1'b1;
    ndac_c_n = 1'b1;
  end
  // ----------------------------------------
  // source: one full handshake per byte
  // ----------------------------------------
  task automatic send(input logic [7:0] b, input logic atn, input logic eoi);
    int k;
    @(posedge mclk);
    #1;
    nrfd_c_n = 1'b1;
    ndac_c_n = 1'b1;
    atn_c_n = ~atn;
    dio_c_n = ~b;
    eoi_c_n = ~eoi;
    // a listener must be present (ndac low) and ready (nrfd high)
    for (k = 0; k < 500 && !(nrfd_n && !ndac_n); k++) begin
      @(posedge mclk);
      #1;
    end
    repeat (2) @(posedge mclk);
    #1 dav_c_n = 1'b0;
    for (k = 0; k < 500 && !ndac_n; k++) begin
      @(posedge mclk);
      #1;
    end
    dav_c_n = 1'b1;
    dio_c_n = 8'hFF;
    eoi_c_n = 1'b1;
    atn_c_n = 1'b1;
    // after addressing the controller listens, not yet ready
    if (atn) begin
      nrfd_c_n = 1'b0;
      ndac_c_n = 1'b0;
    end
  endtask
  // ----------------------------------------
  // acceptor: holds ndac until the byte is taken
  // ----------------------------------------
  task automatic recv(output logic [7:0] b, output logic e);
    int k;
    @(posedge mclk);
    #1;
    ndac_c_n = 1'b0;
    nrfd_c_n = 1'b1;
    for (k = 0; k < 500 && dav_n; k++) @(posedge mclk);
    b = ~dio_n;
    e = ~eoi_n;
    #1;
    nrfd_c_n = 1'b0;
    ndac_c_n = 1'b1;
    for (k = 0; k < 500 && !dav_n; k++) @(posedge mclk);
    #1 ndac_c_n = 1'b0;
  endtask
  task automatic idle();
    @(posedge mclk);
    #1;
    nrfd_c_n = 1'b1;
    ndac_c_n = 1'b1;
  endtask
endmodule

// ---- test_ibtl_core.sv ----
// testbench: talker/listener core against a behavioural controller
`timescale 1ns/100ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin error_cnt++; \
  $display("BAD %s expected %h seen %h", n, e, s); end end
module test_ibtl_core;
  import ibtl_pkg::*;
  localparam logic [7:0] LAD = {1'b0, LAD_LO} | 8'h05;
  localparam logic [7:0] TAD = {1'b0, TAD_LO} | 8'h05;
  logic mclk, rst_n, ren_n, ifc_n, srq_enable, srq_set, rx_ready, tx_last, tx_valid;
  logic local_key, eoi_n_o, eoi_oe, dav_n_o, dav_oe, nrfd_n_o, nrfd_oe, ndac_n_o, ndac_oe;
  logic srq_n_o, srq_oe, rx_valid, tx_ready, remote, lockout, listener, talker;
  logic dev_clear, dev_trigger, srq_pending, c_atn, c_eoi, c_dav, c_nrfd, c_ndac, e0, e1;
  logic [7:0] tx_data, term_char, dio_n_o, dio_oe, rx_data, c_dio, b0, b1;
  logic [4:0] my_addr;
  logic [7:0] rx_q[$];
  int error_cnt, total_checks, clr_cnt, trg_cnt, atn_bad;
  logic [3:0] atn_hist = 4'h0;
  // open-drain lines: low wins, released lines pull up
  wire logic [7:0] dio_l = (~dio_oe | dio_n_o) & c_dio;
  wire logic eoi_l = (~eoi_oe | eoi_n_o) & c_eoi;
  wire logic dav_l = (~dav_oe | dav_n_o) & c_dav;
  wire logic nrfd_l = (~nrfd_oe | nrfd_n_o) & c_nrfd;
  wire logic ndac_l = (~ndac_oe | ndac_n_o) & c_ndac;
  wire logic srq_l = ~srq_oe | srq_n_o;
  ibtl_core dut (.mclk(mclk), .rst_n(rst_n), .dio_n_i(dio_l), .dio_n_o(dio_n_o),
    .dio_oe(dio_oe), .atn_n_i(c_atn), .ren_n_i(ren_n), .ifc_n_i(ifc_n), .eoi_n_i(eoi_l),
    .eoi_n_o(eoi_n_o), .eoi_oe(eoi_oe), .dav_n_i(dav_l), .dav_n_o(dav_n_o), .dav_oe(dav_oe),
    .nrfd_n_i(nrfd_l), .nrfd_n_o(nrfd_n_o), .nrfd_oe(nrfd_oe), .ndac_n_i(ndac_l),
    .ndac_n_o(ndac_n_o), .ndac_oe(ndac_oe), .srq_n_o(srq_n_o), .srq_oe(srq_oe),
    .my_addr(my_addr), .term_char(term_char), .srq_enable(srq_enable), .srq_set(srq_set),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready), .local_key(local_key),
    .remote(remote), .lockout(lockout), .listener(listener), .talker(talker),
    .dev_clear(dev_clear), .dev_trigger(dev_trigger), .srq_pending(srq_pending));
  ibtl_ctl_model ctl (.mclk(mclk), .dio_n(dio_l), .nrfd_n(nrfd_l), .ndac_n(ndac_l),
    .dav_n(dav_l), .eoi_n(eoi_l), .dio_c_n(c_dio), .atn_c_n(c_atn), .eoi_c_n(c_eoi),
    .dav_c_n(c_dav), .nrfd_c_n(c_nrfd), .ndac_c_n(c_ndac));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // rx_ready stays high, so each received byte shows for one cycle
  always @(posedge mclk) begin
    if (rx_valid === 1'b1) rx_q.push_back(rx_data);
    if (dev_clear === 1'b1) clr_cnt++;
    if (dev_trigger === 1'b1) trg_cnt++;
    // the talker needs the synchroniser delay to see attention and let go
    atn_hist <= {atn_hist[2:0], c_atn === 1'b0};
    if (atn_hist == 4'hF && dio_oe !== 8'h00) atn_bad++;
  end
  task automatic step();
    @(posedge mclk);
    #1;
  endtask
  task automatic settle();
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task automatic cmd(input logic [6:0] c);
    ctl.send({1'b0, c}, 1'b1, 1'b0);
    settle();
  endtask
  task automatic key();
    step();
    local_key = 1'b1;
    step();
    local_key = 1'b0;
    settle();
  endtask
  task automatic tx_send(input logic [7:0] b, input logic last);
    int k;
    step();
    tx_data = b;
    tx_last = last;
    tx_valid = 1'b1;
    for (k = 0; k < 500 && tx_ready !== 1'b1; k++) @(negedge mclk);
    step();
    tx_valid = 1'b0;
  endtask
  task automatic s_remote();
    step();
    ren_n = 1'b0;
    cmd(LAD[6:0]);
    `CHK("listener", 1'b1, listener)
    `CHK("remote", 1'b1, remote)
    key();
    `CHK("remote", 1'b0, remote)
    cmd(LAD[6:0]);
    cmd(CMD_GTL);
    `CHK("remote", 1'b0, remote)
    cmd(LAD[6:0]);
    cmd(CMD_LLO);
    key();
    `CHK("lockout", 1'b1, lockout)
    `CHK("remote", 1'b1, remote)
    step();
    ren_n = 1'b1;
    settle();
    `CHK("remote", 1'b0, remote)
    `CHK("lockout", 1'b0, lockout)
  endtask
  task automatic s_rx();
    rx_q.delete();
    ctl.send(8'h41, 1'b0, 1'b0);
    ctl.send({1'b0, CMD_SPE}, 1'b0, 1'b1);
    settle();
    `CHK("rx count", 3, rx_q.size())
    `CHK("rx 0", 8'h41, rx_q[0])
    `CHK("rx 1", {1'b0, CMD_SPE}, rx_q[1])
    `CHK("rx term", 8'h0A, rx_q[2])
  endtask
  task automatic s_cmds();
    clr_cnt = 0;
    trg_cnt = 0;
    cmd(CMD_DCL);
    cmd(CMD_SDC);
    cmd(CMD_GET);
    `CHK("clears", 2, clr_cnt)
    `CHK("triggers", 1, trg_cnt)
    cmd(UNL_CODE);
    `CHK("listener", 1'b0, listener)
    cmd(LAD[6:0] + 7'h01);
    cmd(CMD_SDC);
    cmd(CMD_GET);
    `CHK("listener", 1'b0, listener)
    `CHK("clears", 2, clr_cnt)
    `CHK("triggers", 1, trg_cnt)
  endtask
  task automatic s_talk();
    cmd(TAD[6:0]);
    `CHK("talker", 1'b1, talker)
    fork ctl.recv(b0, e0); tx_send(8'h58, 1'b0); join
    fork ctl.recv(b1, e1); tx_send(term_char, 1'b1); join
    ctl.idle();
    `CHK("tx 0", 8'h58, b0)
    `CHK("eoi 0", 1'b0, e0)
    `CHK("tx term", 8'h0A, b1)
    `CHK("eoi term", 1'b1, e1)
    cmd(7'h61);
    `CHK("talker", 1'b1, talker)
    cmd(UNT_CODE);
    `CHK("talker", 1'b0, talker)
    cmd(TAD[6:0]);
    cmd(TAD[6:0] + 7'h01);
    `CHK("talker", 1'b0, talker)
  endtask
  task automatic s_poll();
    step();
    srq_set = 1'b1;
    step();
    srq_set = 1'b0;
    settle();
    `CHK("srq off", 1'b0, srq_oe)
    srq_enable = 1'b1;
    srq_set = 1'b1;
    step();
    srq_set = 1'b0;
    settle();
    `CHK("srq line", 1'b0, srq_l)
    `CHK("srq pend", 1'b1, srq_pending)
    cmd(CMD_SPE);
    cmd(TAD[6:0]);
    ctl.recv(b0, e0);
    ctl.idle();
    settle();
    `CHK("status", 8'h40, b0)
    `CHK("srq oe", 1'b0, srq_oe)
    `CHK("srq pend", 1'b0, srq_pending)
    cmd(CMD_SPD);
    cmd(UNT_CODE);
  endtask
  task automatic s_ifc();
    cmd(LAD[6:0]);
    cmd(TAD[6:0]);
    ifc_n = 1'b0;
    settle();
    ifc_n = 1'b1;
    settle();
    `CHK("listener", 1'b0, listener)
    `CHK("talker", 1'b0, talker)
    ctl.atn_c_n = 1'b0;
    ctl.eoi_c_n = 1'b0;
    repeat (10) step();
    `CHK("poll drive", 8'h00, dio_oe)
    ctl.atn_c_n = 1'b1;
    ctl.eoi_c_n = 1'b1;
    `CHK("atn drive", 0, atn_bad)
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // the full run needs well under 10000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    {ren_n, ifc_n, rx_ready} = 3'b111;
    {srq_enable, srq_set, tx_last, tx_valid, local_key} = 5'b0_0000;
    tx_data = 8'h00;
    term_char = TERM_DEFAULT;
    my_addr = 5'h05;
    repeat (8) @(posedge mclk);
    #1 rst_n = 1'b1;
    settle();
    s_remote();
    s_rx();
    s_cmds();
    s_talk();
    s_poll();
    s_ifc();
    conclude();
  end
endmodule
